/* File: core/status_map.svh */
// named widths, bit positions and reset values of the status hierarchy
`ifndef STATUS_MAP_SVH
`define STATUS_MAP_SVH

`define GROUP_WIDTH        16
`define STD_WIDTH          8
`define STB_WIDTH          8
`define DATA_WIDTH         16
`define GROUP_COUNT        3

// instrument group indices
`define GRP_QUESTIONABLE_SUMMARY           0
`define GRP_OPERATIONAL_SUMMARY           1
`define GRP_RCVR           2

// standard event bit positions
`define STD_OPC_BIT        0
`define STD_QYE_BIT        2
`define STD_DDE_BIT        3
`define STD_EXE_BIT        4
`define STD_CME_BIT        5
`define STD_PON_BIT        7
`define STD_USED_MASK      8'hBD

// status byte bit positions
`define STB_RCVR_BIT       1
`define STB_ERRQ_BIT       2
`define STB_QUESTIONABLE_SUMMARY_BIT       3
`define STB_OUTP_BIT       4
`define STB_STD_BIT        5
`define STB_MASTER_BIT     6
`define STB_OPERATIONAL_SUMMARY_BIT       7

`define ENABLE_RESET_16    16'h0000
`define ENABLE_RESET_8     8'h00
`define ZERO_16            16'h0000
`define ZERO_8             8'h00

`endif

/* File: core/status_pkg.sv */
// types shared by the status hierarchy
package status_pkg;

    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } cmd_op_t;

    typedef enum logic [3:0] {
        SEL_QUESTIONABLE_SUMMARY_COND   = 4'b0000,
        SEL_QUESTIONABLE_SUMMARY_EVENT  = 4'b0001,
        SEL_QUESTIONABLE_SUMMARY_ENABLE = 4'b0010,
        SEL_OPERATIONAL_SUMMARY_COND   = 4'b0011,
        SEL_OPERATIONAL_SUMMARY_EVENT  = 4'b0100,
        SEL_OPERATIONAL_SUMMARY_ENABLE = 4'b0101,
        SEL_RCVR_COND   = 4'b0110,
        SEL_RCVR_EVENT  = 4'b0111,
        SEL_RCVR_ENABLE = 4'b1000,
        SEL_STD_EVENT   = 4'b1001,
        SEL_STD_ENABLE  = 4'b1010,
        SEL_STATUS_BYTE = 4'b1011,
        SEL_SRQ_ENABLE  = 4'b1100
    } reg_sel_t;

endpackage : status_pkg

/* File: core/status_group.sv */
// one condition / sticky event / enable group with its summary bit
`timescale 1ns/100ps
`include "status_map.svh"

module status_group #(
    parameter int WIDTH = `GROUP_WIDTH
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] state_in,
    input  wire logic [WIDTH-1:0] valid_mask,
    input  wire logic             read_event,
    input  wire logic             clear_status,
    input  wire logic             enable_we,
    input  wire logic [WIDTH-1:0] enable_wdata,
    output logic      [WIDTH-1:0] cond_r,
    output logic      [WIDTH-1:0] event_r,
    output logic      [WIDTH-1:0] enable_r,
    output logic                  summary
);
    logic [WIDTH-1:0] event_nxt;
    logic [WIDTH-1:0] clear_mask;

    // read and clear-status wipe the sticky bits; live inputs re-set them
    assign clear_mask = (read_event || clear_status) ? {WIDTH{1'b1}} : {WIDTH{1'b0}};
    assign event_nxt  = ((event_r & ~clear_mask) | cond_r | state_in) & valid_mask;
    assign summary    = |(event_r & enable_r);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_r   <= {WIDTH{1'b0}};
            event_r  <= {WIDTH{1'b0}};
            enable_r <= {WIDTH{1'b0}};
        end else begin
            cond_r  <= state_in & valid_mask;
            event_r <= event_nxt;
            // enable changes only on an explicit write, zero clears all
            if (enable_we) begin
                enable_r <= enable_wdata;
            end
        end
    end
endmodule : status_group

/* File: core/status_summary_hierarchy.sv */
// status hierarchy: three instrument groups, standard events, status byte
`timescale 1ns/100ps
`include "status_map.svh"

module status_summary_hierarchy
    import status_pkg::*;
#(
    parameter int GROUP_W = `GROUP_WIDTH,
    parameter int STD_W   = `STD_WIDTH
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic [GROUP_W-1:0]       questionable_summary_state,
    input  wire logic [GROUP_W-1:0]       operational_summary_state,
    input  wire logic [GROUP_W-1:0]       rcvr_state,
    input  wire logic                     operation_complete,
    input  wire logic                     query_error,
    input  wire logic                     device_error,
    input  wire logic                     execution_error,
    input  wire logic                     command_error,
    input  wire logic                     error_queue_nonempty,
    input  wire logic                     output_pending,
    input  wire logic                     clear_status,
    input  wire status_pkg::cmd_op_t      cmd_op,
    input  wire status_pkg::reg_sel_t     cmd_sel,
    input  wire logic [`DATA_WIDTH-1:0]   cmd_wdata,
    output logic                          rsp_valid_r,
    output logic      [`DATA_WIDTH-1:0]   rsp_data_r,
    output logic                          cmd_reject_r,
    output logic      [`STB_WIDTH-1:0]    summary_status_byte,
    output logic                          master_summary,
    output logic                          service_request
);
    import status_pkg::*;

    localparam int NG = `GROUP_COUNT;

    // command decode
    logic cmd_read;
    logic cmd_write;
    assign cmd_read  = (cmd_op == OP_READ);
    assign cmd_write = (cmd_op == OP_WRITE);

    logic sel_questionable_summary_cond;
    logic sel_questionable_summary_event;
    logic sel_questionable_summary_enable;
    logic sel_operational_summary_cond;
    logic sel_operational_summary_event;
    logic sel_operational_summary_enable;
    logic sel_rcvr_cond;
    logic sel_rcvr_event;
    logic sel_rcvr_enable;
    logic sel_std_event;
    logic sel_std_enable;
    logic sel_status_byte;
    logic sel_srq_enable;

    assign sel_questionable_summary_cond   = (cmd_sel == SEL_QUESTIONABLE_SUMMARY_COND);
    assign sel_questionable_summary_event  = (cmd_sel == SEL_QUESTIONABLE_SUMMARY_EVENT);
    assign sel_questionable_summary_enable = (cmd_sel == SEL_QUESTIONABLE_SUMMARY_ENABLE);
    assign sel_operational_summary_cond   = (cmd_sel == SEL_OPERATIONAL_SUMMARY_COND);
    assign sel_operational_summary_event  = (cmd_sel == SEL_OPERATIONAL_SUMMARY_EVENT);
    assign sel_operational_summary_enable = (cmd_sel == SEL_OPERATIONAL_SUMMARY_ENABLE);
    assign sel_rcvr_cond   = (cmd_sel == SEL_RCVR_COND);
    assign sel_rcvr_event  = (cmd_sel == SEL_RCVR_EVENT);
    assign sel_rcvr_enable = (cmd_sel == SEL_RCVR_ENABLE);
    assign sel_std_event   = (cmd_sel == SEL_STD_EVENT);
    assign sel_std_enable  = (cmd_sel == SEL_STD_ENABLE);
    assign sel_status_byte = (cmd_sel == SEL_STATUS_BYTE);
    assign sel_srq_enable  = (cmd_sel == SEL_SRQ_ENABLE);

    // only enable masks are writable; everything else is a bad write
    logic any_enable_sel;
    logic sel_known;
    logic write_ok;
    logic bad_cmd;
    assign any_enable_sel = sel_questionable_summary_enable | sel_operational_summary_enable | sel_rcvr_enable
                          | sel_std_enable | sel_srq_enable;
    assign sel_known      = any_enable_sel | sel_questionable_summary_cond | sel_questionable_summary_event
                          | sel_operational_summary_cond | sel_operational_summary_event | sel_rcvr_cond
                          | sel_rcvr_event | sel_std_event | sel_status_byte;
    assign write_ok       = cmd_write & any_enable_sel;
    assign bad_cmd        = (cmd_write & ~any_enable_sel) | (cmd_read & ~sel_known);

    // instrument groups, one generate loop
    logic [GROUP_W-1:0] grp_state  [NG];
    logic [GROUP_W-1:0] grp_cond   [NG];
    logic [GROUP_W-1:0] grp_event  [NG];
    logic [GROUP_W-1:0] grp_enable [NG];
    logic [NG-1:0]      grp_summary;
    logic [NG-1:0]      grp_read_event;
    logic [NG-1:0]      grp_enable_we;

    assign grp_state[`GRP_QUESTIONABLE_SUMMARY] = questionable_summary_state;
    assign grp_state[`GRP_OPERATIONAL_SUMMARY] = operational_summary_state;
    assign grp_state[`GRP_RCVR] = rcvr_state;

    assign grp_read_event[`GRP_QUESTIONABLE_SUMMARY] = cmd_read & sel_questionable_summary_event;
    assign grp_read_event[`GRP_OPERATIONAL_SUMMARY] = cmd_read & sel_operational_summary_event;
    assign grp_read_event[`GRP_RCVR] = cmd_read & sel_rcvr_event;

    assign grp_enable_we[`GRP_QUESTIONABLE_SUMMARY] = write_ok & sel_questionable_summary_enable;
    assign grp_enable_we[`GRP_OPERATIONAL_SUMMARY] = write_ok & sel_operational_summary_enable;
    assign grp_enable_we[`GRP_RCVR] = write_ok & sel_rcvr_enable;

    genvar g;
    generate
        for (g = 0; g < NG; g++) begin : gen_group
            status_group #(
                .WIDTH        (GROUP_W)
            ) u_group (
                .core_clk     (core_clk),
                .rst_n        (rst_n),
                .state_in     (grp_state[g]),
                .valid_mask   ({GROUP_W{1'b1}}),
                .read_event   (grp_read_event[g]),
                .clear_status (clear_status),
                .enable_we    (grp_enable_we[g]),
                .enable_wdata (cmd_wdata[GROUP_W-1:0]),
                .cond_r       (grp_cond[g]),
                .event_r      (grp_event[g]),
                .enable_r     (grp_enable[g]),
                .summary      (grp_summary[g])
            );
        end
    endgenerate

    // standard event register: pulse inputs, power-on marked once after reset
    logic             power_on_pending_r;
    logic             bad_cmd_r;
    logic [STD_W-1:0] std_set;
    logic [STD_W-1:0] std_cond;
    logic [STD_W-1:0] std_event;
    logic [STD_W-1:0] std_enable;
    logic             std_summary;
    logic             std_read_event;
    logic             std_enable_we;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_on_pending_r <= 1'b1;
        end else begin
            power_on_pending_r <= 1'b0;
        end
    end

    // a malformed register command also counts as a command error
    always_comb begin
        std_set                = {STD_W{1'b0}};
        std_set[`STD_OPC_BIT]  = operation_complete;
        std_set[`STD_QYE_BIT]  = query_error;
        std_set[`STD_DDE_BIT]  = device_error;
        std_set[`STD_EXE_BIT]  = execution_error;
        std_set[`STD_CME_BIT]  = command_error | bad_cmd_r;
        std_set[`STD_PON_BIT]  = power_on_pending_r;
    end

    assign std_read_event = cmd_read & sel_std_event;
    assign std_enable_we  = write_ok & sel_std_enable;

    status_group #(
        .WIDTH        (STD_W)
    ) u_std_event (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .state_in     (std_set),
        .valid_mask   (`STD_USED_MASK),
        .read_event   (std_read_event),
        .clear_status (clear_status),
        .enable_we    (std_enable_we),
        .enable_wdata (cmd_wdata[STD_W-1:0]),
        .cond_r       (std_cond),
        .event_r      (std_event),
        .enable_r     (std_enable),
        .summary      (std_summary)
    );

    // summary status byte, no storage of its own apart from service enable
    logic [`STB_WIDTH-1:0] stb_base;
    logic [`STB_WIDTH-1:0] srq_enable_r;
    logic [`STB_WIDTH-1:0] master_mask;

    always_comb begin
        stb_base                  = `ZERO_8;
        stb_base[`STB_RCVR_BIT]   = grp_summary[`GRP_RCVR];
        stb_base[`STB_ERRQ_BIT]   = error_queue_nonempty;
        stb_base[`STB_QUESTIONABLE_SUMMARY_BIT]   = grp_summary[`GRP_QUESTIONABLE_SUMMARY];
        stb_base[`STB_OUTP_BIT]   = output_pending;
        stb_base[`STB_STD_BIT]    = std_summary;
        stb_base[`STB_OPERATIONAL_SUMMARY_BIT]   = grp_summary[`GRP_OPERATIONAL_SUMMARY];
    end

    // bit 6 is left out so the master bit cannot latch itself on
    always_comb begin
        master_mask                  = srq_enable_r;
        master_mask[`STB_MASTER_BIT] = 1'b0;
    end

    assign master_summary = |(stb_base & master_mask);

    always_comb begin
        summary_status_byte                  = stb_base;
        summary_status_byte[`STB_MASTER_BIT] = master_summary;
    end

    assign service_request = master_summary;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            srq_enable_r <= `ENABLE_RESET_8;
        end else if (write_ok && sel_srq_enable) begin
            srq_enable_r <= cmd_wdata[`STB_WIDTH-1:0];
        end
    end

    // read data selection: one weighted word, narrow values zero-extended
    logic [`DATA_WIDTH-1:0] read_mux;

    always_comb begin
        read_mux = `ZERO_16;
        case (cmd_sel)
            SEL_QUESTIONABLE_SUMMARY_COND:   read_mux = grp_cond[`GRP_QUESTIONABLE_SUMMARY];
            SEL_QUESTIONABLE_SUMMARY_EVENT:  read_mux = grp_event[`GRP_QUESTIONABLE_SUMMARY];
            SEL_QUESTIONABLE_SUMMARY_ENABLE: read_mux = grp_enable[`GRP_QUESTIONABLE_SUMMARY];
            SEL_OPERATIONAL_SUMMARY_COND:   read_mux = grp_cond[`GRP_OPERATIONAL_SUMMARY];
            SEL_OPERATIONAL_SUMMARY_EVENT:  read_mux = grp_event[`GRP_OPERATIONAL_SUMMARY];
            SEL_OPERATIONAL_SUMMARY_ENABLE: read_mux = grp_enable[`GRP_OPERATIONAL_SUMMARY];
            SEL_RCVR_COND:   read_mux = grp_cond[`GRP_RCVR];
            SEL_RCVR_EVENT:  read_mux = grp_event[`GRP_RCVR];
            SEL_RCVR_ENABLE: read_mux = grp_enable[`GRP_RCVR];
            SEL_STD_EVENT:   read_mux = {8'h00, std_event};
            SEL_STD_ENABLE:  read_mux = {8'h00, std_enable};
            SEL_STATUS_BYTE: read_mux = {8'h00, summary_status_byte};
            SEL_SRQ_ENABLE:  read_mux = {8'h00, srq_enable_r};
            default:         read_mux = `ZERO_16;
        endcase
    end

    // answer one cycle after the command; the event value is pre-clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_r  <= 1'b0;
            rsp_data_r   <= `ZERO_16;
            cmd_reject_r <= 1'b0;
            bad_cmd_r    <= 1'b0;
        end else begin
            rsp_valid_r  <= cmd_read & sel_known;
            rsp_data_r   <= (cmd_read & sel_known) ? read_mux : `ZERO_16;
            cmd_reject_r <= bad_cmd;
            bad_cmd_r    <= bad_cmd;
        end
    end

    // unused: standard condition copy carries nothing beyond the event set
    logic std_cond_unused;
    assign std_cond_unused = |std_cond;

endmodule : status_summary_hierarchy

/* File: verification/status_summary_hierarchy_properties.sv */
// port-level assertions for the status hierarchy
`timescale 1ns/100ps
`include "status_map.svh"

module status_summary_hierarchy_properties
    import status_pkg::*;
#(
    parameter int GROUP_W = `GROUP_WIDTH,
    parameter int STD_W   = `STD_WIDTH
) (
    input wire logic                   core_clk,
    input wire logic                   rst_n,
    input wire logic [GROUP_W-1:0]     questionable_summary_state,
    input wire logic [GROUP_W-1:0]     operational_summary_state,
    input wire logic                   error_queue_nonempty,
    input wire logic                   output_pending,
    input wire status_pkg::cmd_op_t    cmd_op,
    input wire status_pkg::reg_sel_t   cmd_sel,
    input wire logic [`DATA_WIDTH-1:0] cmd_wdata,
    input wire logic                   rsp_valid_r,
    input wire logic [`DATA_WIDTH-1:0] rsp_data_r,
    input wire logic                   cmd_reject_r,
    input wire logic [`STB_WIDTH-1:0]  summary_status_byte,
    input wire logic                   master_summary,
    input wire logic                   service_request
);
    logic [1:0] up_r;

    // past values from inside reset would mislead the history-based checks
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) up_r <= 2'h0;
        else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence cond_rd_s;
        up_r == 2'h3 && cmd_op == OP_READ && cmd_sel == SEL_QUESTIONABLE_SUMMARY_COND;
    endsequence
    sequence operational_summary_evt_rd_s;
        up_r == 2'h3 && cmd_op == OP_READ && cmd_sel == SEL_OPERATIONAL_SUMMARY_EVENT;
    endsequence

    chk_service_follows_master: assert property (service_request == master_summary)
        else $error("service request differs from master summary");
    chk_master_in_byte: assert property (summary_status_byte[6] == master_summary)
        else $error("status byte bit 6 differs from master summary");
    chk_errq_bit_live: assert property (summary_status_byte[2] == error_queue_nonempty)
        else $error("status byte bit 2 wrong");
    chk_outp_bit_live: assert property (summary_status_byte[4] == output_pending)
        else $error("status byte bit 4 wrong");
    chk_read_gets_answer: assert property (
        cmd_op == OP_READ && cmd_sel <= SEL_SRQ_ENABLE |=> rsp_valid_r && !cmd_reject_r)
        else $error("read not answered next cycle");
    chk_bad_write_refused: assert property (
        cmd_op == OP_WRITE && (cmd_sel == SEL_QUESTIONABLE_SUMMARY_COND || cmd_sel == SEL_STATUS_BYTE)
        |=> cmd_reject_r && !rsp_valid_r)
        else $error("write to read-only place not refused");
    chk_cond_follows_state: assert property (
        $stable(questionable_summary_state)[*2] ##0 cond_rd_s |=> rsp_data_r == $past(questionable_summary_state))
        else $error("condition read differs from steady state");
    chk_event_holds_set: assert property (
        operational_summary_evt_rd_s |=> (rsp_data_r & $past(operational_summary_state, 2)) == $past(operational_summary_state, 2))
        else $error("event read lost a set bit");
    chk_zero_enable_quiet: assert property (
        cmd_op == OP_WRITE && cmd_sel == SEL_QUESTIONABLE_SUMMARY_ENABLE && cmd_wdata == 16'h0000
        |=> !summary_status_byte[3])
        else $error("summary set after zero enable");
endmodule : status_summary_hierarchy_properties

bind status_summary_hierarchy status_summary_hierarchy_properties #(
    .GROUP_W(GROUP_W), .STD_W(STD_W)
) i_status_summary_hierarchy_properties (
    .core_clk(core_clk), .rst_n(rst_n), .questionable_summary_state(questionable_summary_state), .operational_summary_state(operational_summary_state),
    .error_queue_nonempty(error_queue_nonempty), .output_pending(output_pending),
    .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_valid_r(rsp_valid_r),
    .rsp_data_r(rsp_data_r), .cmd_reject_r(cmd_reject_r),
    .summary_status_byte(summary_status_byte), .master_summary(master_summary),
    .service_request(service_request)
);

/* File: verification/host_model.sv */
// remote host controller model driving the command port
`timescale 1ns/100ps
`include "status_map.svh"

module host_model
    import status_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   rsp_valid_r,
    input  wire logic [`DATA_WIDTH-1:0] rsp_data_r,
    input  wire logic                   cmd_reject_r,
    output status_pkg::cmd_op_t         cmd_op,
    output status_pkg::reg_sel_t        cmd_sel,
    output logic      [`DATA_WIDTH-1:0] cmd_wdata
);
    initial begin
        cmd_op    = OP_IDLE;
        cmd_sel   = SEL_STATUS_BYTE;
        cmd_wdata = 16'h0000;
    end

    // one command held for one cycle, answer taken just after the next clock edge
    task automatic xfer(input cmd_op_t op, input reg_sel_t sel, input logic [15:0] wd,
                        output logic [15:0] rd, output logic vld, output logic rej);
        @(posedge core_clk);
        #1;
        cmd_op    = op;
        cmd_sel   = sel;
        cmd_wdata = wd;
        @(posedge core_clk);
        #1;
        rd        = rsp_data_r;
        vld       = rsp_valid_r;
        rej       = cmd_reject_r;
        cmd_op    = OP_IDLE;
        // idle data is not held, so stale values cannot pass for writes
        cmd_wdata = ~wd;
    endtask : xfer
endmodule : host_model

/* File: verification/tb_status_summary_hierarchy.sv */
// self-checking bench for the status hierarchy
`timescale 1ns/100ps
`include "status_map.svh"

module tb_status_summary_hierarchy;
    import status_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] st [3] = '{16'h0000, 16'h0000, 16'h0000};
    logic [4:0]  std_in = 5'h00;
    logic        errq = 1'b0;
    logic        outp = 1'b0;
    logic        cls = 1'b0;
    cmd_op_t     cmd_op;
    reg_sel_t    cmd_sel;
    logic [15:0] cmd_wdata, rsp_data_r, rd_v, s, e;
    logic        rsp_valid_r, cmd_reject_r, vld, rej, master_summary, service_request;
    logic [7:0]  stb;
    int          num_errors = 0;
    int          check_count = 0;
    int          cyc = 0;
    integer      seed;

    always #10 core_clk = ~core_clk;

    status_summary_hierarchy i_status_summary_hierarchy (
        .core_clk(core_clk), .rst_n(rst_n), .questionable_summary_state(st[0]), .operational_summary_state(st[1]),
        .rcvr_state(st[2]), .operation_complete(std_in[0]), .query_error(std_in[1]),
        .device_error(std_in[2]), .execution_error(std_in[3]), .command_error(std_in[4]),
        .error_queue_nonempty(errq), .output_pending(outp), .clear_status(cls),
        .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_valid_r(rsp_valid_r),
        .rsp_data_r(rsp_data_r), .cmd_reject_r(cmd_reject_r), .summary_status_byte(stb),
        .master_summary(master_summary), .service_request(service_request));
    host_model i_host_model (
        .core_clk(core_clk), .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r),
        .cmd_reject_r(cmd_reject_r), .cmd_op(cmd_op), .cmd_sel(cmd_sel),
        .cmd_wdata(cmd_wdata));

    function automatic int grp_bit(input int g);
        return (g == 0) ? 3 : ((g == 1) ? 7 : 1);
    endfunction : grp_bit
    function automatic logic [15:0] std_exp(input int i);
        return 16'h0001 << ((i == 0) ? 0 : i + 1);
    endfunction : std_exp
    function automatic reg_sel_t sel_of(input int g, input int k);
        return reg_sel_t'(4'(g * 3 + k));
    endfunction : sel_of

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd(input reg_sel_t sel, input logic [15:0] exp);
        i_host_model.xfer(OP_READ, sel, 16'h0000, rd_v, vld, rej);
        chk({15'h0000, vld}, 16'h0001);
        chk(rd_v, exp);
    endtask : rd
    task automatic wr(input reg_sel_t sel, input logic [15:0] d);
        i_host_model.xfer(OP_WRITE, sel, d, rd_v, vld, rej);
        chk({15'h0000, rej}, 16'h0000);
    endtask : wr
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask : step
    task automatic summarize;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        seed = 32'h13472fb7;
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        rd(SEL_STD_EVENT, 16'h0080);
        // power-on condition was still high at the first clear, so it re-sets once
        rd(SEL_STD_EVENT, 16'h0080);
        rd(SEL_STD_EVENT, 16'h0000);
        for (int it = 0; it < 4; it++) begin
            for (int g = 0; g < 3; g++) begin
                s = 16'($random(seed));
                e = 16'($random(seed)) | 16'h0001;
                st[g] = s;
                rd(sel_of(g, 0), s);
                rd(sel_of(g, 1), s);
                rd(sel_of(g, 1), s);
                st[g] = 16'h0000;
                rd(sel_of(g, 0), 16'h0000);
                rd(sel_of(g, 1), s);
                rd(sel_of(g, 1), 16'h0000);
                wr(sel_of(g, 2), e);
                chk(16'(stb[grp_bit(g)]), 16'h0000);
                st[g] = e;
                step();
                st[g] = 16'h0000;
                step();
                chk(16'(stb[grp_bit(g)]), 16'h0001);
                cls = 1'b1;
                step();
                cls = 1'b0;
                step();
                chk(16'(stb[grp_bit(g)]), 16'h0000);
                rd(sel_of(g, 2), e);
                wr(sel_of(g, 2), 16'h0000);
                st[g] = 16'hFFFF;
                step();
                st[g] = 16'h0000;
                step();
                chk(16'(stb[grp_bit(g)]), 16'h0000);
                rd(sel_of(g, 1), 16'hFFFF);
            end
        end
        for (int i = 0; i < 5; i++) begin
            std_in[i] = 1'b1;
            step();
            std_in[i] = 1'b0;
            rd(SEL_STD_EVENT, std_exp(i));
            wr(SEL_STD_ENABLE, std_exp(i));
            std_in[i] = 1'b1;
            step();
            std_in[i] = 1'b0;
            step();
            chk(16'(stb[5]), 16'h0001);
            rd(SEL_STD_EVENT, std_exp(i));
            chk(16'(stb[5]), 16'h0000);
        end
        errq = 1'b1;
        wr(SEL_SRQ_ENABLE, 16'h0040);
        chk({14'h0000, stb[2], master_summary}, 16'h0002);
        wr(SEL_SRQ_ENABLE, 16'h0004);
        chk({14'h0000, master_summary, service_request}, 16'h0003);
        errq = 1'b0;
        outp = 1'b1;
        step();
        chk({8'h00, stb}, 16'h0010);
        rd(SEL_SRQ_ENABLE, 16'h0004);
        i_host_model.xfer(OP_WRITE, SEL_QUESTIONABLE_SUMMARY_COND, 16'h1234, rd_v, vld, rej);
        chk({15'h0000, rej}, 16'h0001);
        rd(SEL_QUESTIONABLE_SUMMARY_COND, 16'h0000);
        rd(SEL_STD_EVENT, 16'h0020);
        summarize();
    end
endmodule : tb_status_summary_hierarchy
